// file: crypto_done_status_flags.sv
// completion, ready and bus fault status flags of the crypto control register
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - summary done flag sets when any counted engine done flag is set by hardware
// - summary done flag stays set until software clears it
// - writing zero to engine done flags leaves summary done unchanged
// - mask bit set: transfer done sets own flag but not summary
// - policy bit zero: direct writes to done flags; one: write-one-to-clear
// - ready flag read-only, one after reset, low during accelerator reset
// - bus fault flag sets on transfer engine access to bad memory
// - bus fault flag ignores writes, cleared only by accelerator reset
// - modular arithmetic done sets on finish, read-only while running
// - cipher done sets to one when a cipher operation finishes
// - hash done sets to one when a hash operation finishes
// - galois done sets on galois or crc finish; a hardware set wins over a same-cycle software clear
// - transfer done sets when an internal transfer completes
module crypto_done_status_flags
    import crypto_done_status_pkg::*;
(
    // clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            srst_i,
    // register port
    input  wire logic [7:0]      reg_addr_i,
    input  wire logic [31:0]     reg_wdata_i,
    input  wire logic            reg_wr_i,
    input  wire logic            reg_rd_i,
    output logic      [31:0]     reg_rdata_o,
    // engine events
    input  wire engine_done_type eng_done_i,
    input  wire logic            maa_busy_i,
    input  wire logic            dma_bus_err_i,
    // accelerator control and interrupt
    output logic                 acc_rst_o,
    output logic                 irq_o
);

`include "crypto_done_status_flags_params.svh"

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    reg_req_type req;
    logic        wr_ctrl;
    logic        wr_ien;
    logic        wr_iclr;

    assign req     = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
    assign wr_ctrl = req.wr && (req.addr == `CDS_OFF_CTRL);
    assign wr_ien  = req.wr && (req.addr == `CDS_OFF_IRQ_ENABLE);
    assign wr_iclr = req.wr && (req.addr == `CDS_OFF_IRQ_CLEAR);

    // ------------------------------------------------------------
    // accelerator reset and ready
    // ------------------------------------------------------------
    logic ready;
    logic acc_rst;
    logic rst_req;
    logic acc_wipe;

    // the request bit is self-clearing, so it is never stored
    assign rst_req  = wr_ctrl && req.wdata[`CDS_BIT_RST_REQ];
    // wipe from the request edge on, so no stale flag reads back while not ready
    assign acc_wipe = rst_req || acc_rst;

    crypto_reset_seq u_reset_seq (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .rst_req_i (rst_req),
        .ready_o   (ready),
        .acc_rst_o (acc_rst)
    );

    // ------------------------------------------------------------
    // control bits and done flags
    // ------------------------------------------------------------
    logic       dma_mask;
    logic       flag_mode;
    logic       done_sum;
    logic       bus_err;
    logic [4:0] flags;
    logic       next_dma_mask;
    logic       next_flag_mode;
    logic       next_done_sum;
    logic       next_bus_err;
    logic [4:0] next_flags;
    logic [4:0] set_vec;
    logic [4:0] sw_val;
    logic [4:0] wr_en_vec;
    logic       sum_set;

    // flag vector order: maa, cph, hsh, gls, dma
    assign set_vec = eng_done_i;
    assign sw_val  = req.wdata[`CDS_BIT_MAA:`CDS_BIT_DMA];
    // modular arithmetic flag locked while that engine runs
    assign wr_en_vec = {wr_ctrl && !maa_busy_i, {4{wr_ctrl}}};
    // modular arithmetic done is not part of the summary
    assign sum_set = eng_done_i.cph || eng_done_i.hsh || eng_done_i.gls
                   || (eng_done_i.dma && !dma_mask);

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_flag
            always_comb begin
                next_flags[g] = flags[g];
                if (wr_en_vec[g]) begin
                    if (flag_mode) begin
                        if (sw_val[g]) begin
                            next_flags[g] = 1'h0;
                        end
                    end else begin
                        next_flags[g] = sw_val[g];
                    end
                end
                // set dominates a same-cycle clear
                if (set_vec[g]) begin
                    next_flags[g] = 1'h1;
                end
            end
        end
    endgenerate

    always_comb begin
        next_dma_mask  = dma_mask;
        next_flag_mode = flag_mode;
        next_done_sum  = done_sum;
        next_bus_err   = bus_err;
        if (wr_ctrl) begin
            next_dma_mask  = req.wdata[`CDS_BIT_DMA_MASK];
            next_flag_mode = req.wdata[`CDS_BIT_FLAG_MODE];
            // only an explicit write to the summary bit touches it
            if (flag_mode) begin
                if (req.wdata[`CDS_BIT_DONE]) begin
                    next_done_sum = 1'h0;
                end
            end else begin
                next_done_sum = req.wdata[`CDS_BIT_DONE];
            end
        end
        if (sum_set) begin
            next_done_sum = 1'h1;
        end
        // software writes never reach the fault flag
        if (acc_wipe) begin
            next_bus_err = 1'h0;
        end else if (dma_bus_err_i) begin
            next_bus_err = 1'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            dma_mask  <= 1'h0;
            flag_mode <= 1'h0;
            done_sum  <= 1'h0;
            bus_err   <= 1'h0;
            flags     <= `CDS_RST_FLAGS;
        end else if (acc_wipe) begin
            // accelerator reset wipes status but keeps the mode bits
            dma_mask  <= next_dma_mask;
            flag_mode <= next_flag_mode;
            done_sum  <= 1'h0;
            bus_err   <= 1'h0;
            flags     <= `CDS_RST_FLAGS;
        end else begin
            dma_mask  <= next_dma_mask;
            flag_mode <= next_flag_mode;
            done_sum  <= next_done_sum;
            bus_err   <= next_bus_err;
            flags     <= next_flags;
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    // events: bit0 summary done, bit1 bus fault, bit2 ready return
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [2:0] next_irq_stat;
    logic [2:0] next_irq_en;
    logic [2:0] irq_evt;
    logic       ready_q;

    // engine pulses dropped by a wipe raise no summary event either
    assign irq_evt = {ready && !ready_q, next_bus_err && !bus_err, sum_set && !acc_wipe};

    always_comb begin
        next_irq_en   = wr_ien ? req.wdata[2:0] : irq_en;
        next_irq_stat = irq_stat;
        if (wr_iclr) begin
            next_irq_stat = irq_stat & ~req.wdata[2:0];
        end
        // events win over a clear in the same cycle
        next_irq_stat = next_irq_stat | irq_evt;
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            irq_stat <= `CDS_RST_IRQ;
            irq_en   <= `CDS_RST_IRQ;
            ready_q  <= `CDS_RST_RDY;
        end else begin
            irq_stat <= next_irq_stat;
            irq_en   <= next_irq_en;
            ready_q  <= ready;
        end
    end

    assign irq_o = |(irq_stat & irq_en);

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    logic [31:0] ctrl_word;
    logic [31:0] next_rdata;
    logic [31:0] rdata;

    always_comb begin
        ctrl_word                            = 32'h00000000;
        ctrl_word[`CDS_BIT_DONE]             = done_sum;
        ctrl_word[`CDS_BIT_RDY]              = ready;
        ctrl_word[`CDS_BIT_ERR]              = bus_err;
        ctrl_word[`CDS_BIT_MAA:`CDS_BIT_DMA] = flags;
        ctrl_word[`CDS_BIT_DMA_MASK]         = dma_mask;
        ctrl_word[`CDS_BIT_FLAG_MODE]        = flag_mode;
        next_rdata                           = 32'h00000000;
        if (req.rd) begin
            case (req.addr)
                `CDS_OFF_CTRL:       next_rdata = ctrl_word;
                `CDS_OFF_IRQ_STATUS: next_rdata = {29'h00000000, irq_stat};
                `CDS_OFF_IRQ_ENABLE: next_rdata = {29'h00000000, irq_en};
                default:             next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign reg_rdata_o = rdata;
    assign acc_rst_o   = acc_rst;

endmodule : crypto_done_status_flags

`default_nettype wire

// file: crypto_done_status_flags_params.svh
// offsets, field positions, reset values and timing counts for the completion status block
`ifndef CRYPTO_DONE_STATUS_FLAGS_PARAMS_SVH
`define CRYPTO_DONE_STATUS_FLAGS_PARAMS_SVH

`define CDS_ADDR_W          8
`define CDS_OFF_CTRL        8'h00
`define CDS_OFF_IRQ_STATUS  8'h04
`define CDS_OFF_IRQ_ENABLE  8'h08
`define CDS_OFF_IRQ_CLEAR   8'h0C

`define CDS_BIT_DONE        31
`define CDS_BIT_RDY         30
`define CDS_BIT_ERR         29
`define CDS_BIT_MAA         28
`define CDS_BIT_CPH         27
`define CDS_BIT_HSH         26
`define CDS_BIT_GLS         25
`define CDS_BIT_DMA         24
`define CDS_BIT_DMA_MASK    15
`define CDS_BIT_FLAG_MODE   14
`define CDS_BIT_RST_REQ     0

`define CDS_RST_RDY         1'h1
`define CDS_RST_FLAGS       5'h00
`define CDS_RST_IRQ         3'h0

// cycles the ready flag stays low after a reset request
`define CDS_RESET_HOLD_CYC  4'h8

`endif

// file: crypto_done_status_monitor.sv
// checker for the completion status register block
`timescale 1ns/1ps
`default_nettype none
module crypto_done_status_monitor
    import crypto_done_status_pkg::*;
(
    // clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            srst_i,
    // register port
    input  wire logic [7:0]      reg_addr_i,
    input  wire logic [31:0]     reg_wdata_i,
    input  wire logic            reg_wr_i,
    input  wire logic            reg_rd_i,
    input  wire logic [31:0]     reg_rdata_o,
    // events and outputs
    input  wire engine_done_type eng_done_i,
    input  wire logic            maa_busy_i,
    input  wire logic            dma_bus_err_i,
    input  wire logic            acc_rst_o,
    input  wire logic            irq_o
);
    // ------
    // properties
    // ------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    logic rd_ctrl;
    logic any_sum;
    assign rd_ctrl = reg_rd_i && reg_addr_i == 8'h00;
    assign any_sum = eng_done_i.cph | eng_done_i.hsh | eng_done_i.gls;
    property p_rdata_idle; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_rst_req;
        reg_wr_i && reg_addr_i == 8'h00 && reg_wdata_i[0] && !acc_rst_o |=> acc_rst_o;
    endproperty
    a_rst_req: assert property (p_rst_req) else $error("reset request ignored");
    property p_rst_len; $rose(acc_rst_o) |-> acc_rst_o [*8] ##1 !acc_rst_o; endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset hold length wrong");
    property p_rdy; rd_ctrl |=> reg_rdata_o[30] == !$past(acc_rst_o); endproperty
    a_rdy: assert property (p_rdy) else $error("ready flag wrong");
    property p_hold0; rd_ctrl && acc_rst_o |=> reg_rdata_o[31:24] == 8'h00; endproperty
    a_hold0: assert property (p_hold0) else $error("flags not cleared in reset");
    property p_done_set; (any_sum && !acc_rst_o) ##1 (rd_ctrl && !acc_rst_o) |=> reg_rdata_o[31];
    endproperty
    a_done_set: assert property (p_done_set) else $error("summary not set");
    property p_own_flag;
        (eng_done_i.dma && !acc_rst_o) ##1 (rd_ctrl && !acc_rst_o) |=> reg_rdata_o[24];
    endproperty
    a_own_flag: assert property (p_own_flag) else $error("transfer flag not set");
    property p_err_set;
        (dma_bus_err_i && !acc_rst_o) ##1 (rd_ctrl && !acc_rst_o) |=> reg_rdata_o[29];
    endproperty
    a_err_set: assert property (p_err_set) else $error("bus fault flag not set");
    property p_clr_reads0; reg_rd_i && reg_addr_i == 8'h0C |=> reg_rdata_o == 32'h0; endproperty
    a_clr_reads0: assert property (p_clr_reads0) else $error("clear register readable");
    c_rst: cover property ($rose(acc_rst_o));
    c_irq: cover property ($rose(irq_o));
    c_done: cover property (rd_ctrl ##1 reg_rdata_o[31]);
endmodule : crypto_done_status_monitor

bind crypto_done_status_flags crypto_done_status_monitor mon (.ref_clk_i(ref_clk_i),
    .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .eng_done_i(eng_done_i),
    .maa_busy_i(maa_busy_i), .dma_bus_err_i(dma_bus_err_i), .acc_rst_o(acc_rst_o), .irq_o(irq_o));
`default_nettype wire

// file: crypto_done_status_pkg.sv
// types shared by the completion status block
package crypto_done_status_pkg;

    // engine completion pulses, one bit each
    typedef struct packed {
        logic maa;
        logic cph;
        logic hsh;
        logic gls;
        logic dma;
    } engine_done_type;

    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_type;

    typedef enum logic [1:0] {
        ACC_READY,
        ACC_RESETTING
    } acc_state_type;

endpackage : crypto_done_status_pkg

// file: crypto_reset_seq.sv
// accelerator soft reset sequencer driving the ready flag
`timescale 1ns/1ps
`default_nettype none

module crypto_reset_seq
    import crypto_done_status_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    // control
    input  wire logic rst_req_i,
    // status
    output logic      ready_o,
    output logic      acc_rst_o
);

`include "crypto_done_status_flags_params.svh"

    acc_state_type state;
    acc_state_type next_state;
    logic [3:0]    cnt;
    logic [3:0]    next_cnt;
    logic          ready;
    logic          next_ready;

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_ready = ready;
        case (state)
            ACC_READY: begin
                if (rst_req_i) begin
                    next_state = ACC_RESETTING;
                    next_cnt   = `CDS_RESET_HOLD_CYC;
                    next_ready = 1'h0;
                end
            end
            ACC_RESETTING: begin
                // a repeated request restarts the hold
                if (rst_req_i) begin
                    next_cnt = `CDS_RESET_HOLD_CYC;
                end else if (cnt == 4'h1) begin
                    next_state = ACC_READY;
                    next_ready = 1'h1;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            default: begin
                next_state = ACC_READY;
                next_ready = 1'h1;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state <= ACC_READY;
            cnt   <= 4'h0;
            ready <= `CDS_RST_RDY;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            ready <= next_ready;
        end
    end

    assign ready_o   = ready;
    assign acc_rst_o = (state == ACC_RESETTING);

endmodule : crypto_reset_seq

`default_nettype wire

// file: tb_top.sv
// self-checking bench for the completion status register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
    import crypto_done_status_pkg::*;
    logic            clk = 1'b0;
    logic            srst = 1'b1;
    logic [7:0]      addr = 8'h00;
    logic [31:0]     wdata = 32'h0;
    logic            wr = 1'b0;
    logic            rd = 1'b0;
    engine_done_type eng = '0;
    logic            busy = 1'b0;
    logic            berr = 1'b0;
    logic [31:0]     rdata;
    logic            acc_rst;
    logic            irq;
    logic [31:0]     m;
    logic [31:0]     v;
    logic [31:0]     w;
    int              miscompares = 0;
    int              samples_checked = 0;
    crypto_done_status_flags uut (.ref_clk_i(clk), .srst_i(srst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .eng_done_i(eng),
        .maa_busy_i(busy), .dma_bus_err_i(berr), .acc_rst_o(acc_rst), .irq_o(irq));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // ------
    // model and bus tasks
    // ------
    // mode bit sampled before the write, so a mode change takes effect one write later
    function automatic logic [31:0] f_wr(logic [31:0] o, logic [31:0] x);
        logic [31:0] r;
        r = o[14] ? (o & ~(x & 32'h9F00_0000)) : ((o & ~32'h9F00_0000) | (x & 32'h9F00_0000));
        r[15:14] = x[15:14];
        return r;
    endfunction : f_wr
    function automatic logic [31:0] f_set(logic [31:0] o, engine_done_type d);
        logic [31:0] r;
        r = o | {3'h0, d, 24'h0};
        if (d.cph | d.hsh | d.gls | (d.dma & !o[15])) r[31] = 1'b1;
        return r;
    endfunction : f_set
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk);
        addr <= a; wdata <= x; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] x);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        x = rdata;
    endtask : rd_reg
    task automatic chk_ctrl(input string n);
        rd_reg(8'h00, v);
        `CHK(n, m, v)
    endtask : chk_ctrl
    // read placed right after the event so the summary and fault checks see it
    task automatic pulse(input engine_done_type d, input logic e);
        @(posedge clk);
        eng <= d; berr <= e;
        @(posedge clk);
        eng <= '0; berr <= 1'b0; addr <= 8'h00; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        m = f_set(m, d);
        m[29] = m[29] | e;
        `CHK("pulse", m, rdata)
    endtask : pulse
    task automatic summarize;
        if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    // ------
    // scenarios
    // ------
    initial begin
        m = 32'h4000_0000;
        v = $urandom(86);
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        chk_ctrl("reset");
        repeat (30) begin
            w = $urandom & 32'h9F00_8000;
            // engine flags cleared before each new operation starts
            wr_reg(8'h00, w & 32'h8000_8000);
            m = f_wr(m, w & 32'h8000_8000);
            pulse(engine_done_type'(5'($urandom)), 1'b0);
            wr_reg(8'h00, w);
            m = f_wr(m, w);
            chk_ctrl("write");
        end
        wr_reg(8'h00, 32'h0000_4000);
        m = f_wr(m, 32'h0000_4000);
        pulse(5'h1F, 1'b0);
        wr_reg(8'h00, 32'h1F00_4000);
        m = f_wr(m, 32'h1F00_4000);
        chk_ctrl("w1c");
        @(posedge clk);
        eng <= 5'h08; wr <= 1'b1; addr <= 8'h00; wdata <= 32'h8800_4000;
        @(posedge clk);
        eng <= '0; wr <= 1'b0;
        m = f_set(f_wr(m, 32'h8800_4000), 5'h08);
        chk_ctrl("same cycle");
        wr_reg(8'h00, 32'h9F00_4000);
        m = f_wr(m, 32'h9F00_4000);
        pulse(5'h10, 1'b0);
        @(posedge clk) busy <= 1'b1;
        wr_reg(8'h00, 32'h1000_4000);
        chk_ctrl("busy");
        @(posedge clk) busy <= 1'b0;
        wr_reg(8'h00, 32'h1000_4000);
        m = f_wr(m, 32'h1000_4000);
        chk_ctrl("idle");
        wr_reg(8'h00, 32'h0000_C000);
        m = f_wr(m, 32'h0000_C000);
        pulse(5'h01, 1'b0);
        pulse(5'h00, 1'b1);
        wr_reg(8'h00, 32'h2000_C000);
        chk_ctrl("fault");
        wr_reg(8'h0C, 32'h7);
        wr_reg(8'h08, 32'h1);
        pulse(5'h08, 1'b0);
        `CHK("irq", 1'b1, irq)
        rd_reg(8'h04, v);
        `CHK("status", 1'b1, v[0])
        wr_reg(8'h08, 32'h0);
        `CHK("masked", 1'b0, irq)
        wr_reg(8'h08, 32'h1);
        wr_reg(8'h0C, 32'h1);
        `CHK("cleared", 1'b0, irq)
        rd_reg(8'h40, v);
        `CHK("unmapped", 32'h0, v)
        wr_reg(8'h00, 32'h0000_C001);
        m = 32'h0000_C000;
        chk_ctrl("resetting");
        // nothing is used until the ready flag reads back one
        for (int i = 0; i < 20 && !v[30]; i++) rd_reg(8'h00, v);
        if (!v[30]) miscompares++;
        m = 32'h4000_C000;
        chk_ctrl("ready");
        summarize();
    end
endmodule : tb_top
`default_nettype wire
